// ---- ohci_irq_defines.vh ----
`ifndef OHCI_IRQ_DEFINES_VH
`define OHCI_IRQ_DEFINES_VH

// ==========================================================
// Register offsets from the base address
`define IRQ_ENABLE_SET_OFS 8'h10
`define IRQ_ENABLE_CLEAR_OFS 8'h14

// ==========================================================
// Field positions
`define MASTER_IRQ_GATE_BIT 31
`define OWNERSHIP_CHANGE_BIT 30
`define ROOT_PORT_CHANGE_BIT 6
`define FRAME_COUNT_WRAP_BIT 5
`define FATAL_FAULT_BIT 4
`define RESUME_DETECT_BIT 3
`define FRAME_BEGIN_BIT 2
`define COMPLETION_POSTED_BIT 1
`define SCHED_OVERRUN_BIT 0

// ==========================================================
// Implemented bits and reset value
`define IRQ_ENABLE_MASK 32'hC000007F
`define IRQ_ENABLE_RESET 32'h00000000

`endif

// ---- ohci_irq_enable_pair.v ----
`timescale 1ns/1ps
// Summary of operation
// - Enable register at 10h; bit 31 gates all
// - Bit 30 enables ownership change; 0 ignored
// - Bit 6 enables root port change; 0 ignored
// - Bit 5 enables frame wrap; 0 ignored
// - Bit 4 enables fatal fault; 0 ignored
// - Bit 3 enables resume detect; 0 ignored
// - Bit 2 enables frame begin; 0 ignored
// - Bit 1 enables completion list posted; 0 ignored
// - Bit 0 enables scheduling overrun; 0 ignored
// - Disable bits align with status and enable bits
// - Disable write of 1 clears enable bit
// - Disable write of 0 leaves bit alone
// - Disable read returns enable register contents
// - One word; reserved bits zero; reset zero
// - After any reset interrupts are disabled
`include "ohci_irq_defines.vh"

module ohci_irq_enable_pair (
    input wire ref_clk,
    input wire rst,
    input wire soft_rst,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata,
    input wire [31:0] irq_event_flags,
    output wire [31:0] irq_enable_view,
    output wire irq_out
);

    // ==========================================================
    // Local constants
    localparam WORD_W = 32;
    localparam ADDR_W = 8;
    localparam EVENT_N = 8;
    localparam [ADDR_W-1:0] SET_OFS = `IRQ_ENABLE_SET_OFS;
    localparam [ADDR_W-1:0] CLEAR_OFS = `IRQ_ENABLE_CLEAR_OFS;
    localparam [WORD_W-1:0] IMPL_MASK = `IRQ_ENABLE_MASK;
    localparam [WORD_W-1:0] RESET_VAL = `IRQ_ENABLE_RESET;
    localparam [WORD_W-1:0] ZERO_WORD = 32'h00000000;
    // Slots of the pending vector
    localparam PEND_OWNERSHIP = 7;
    localparam PEND_ROOT_PORT = 6;
    localparam PEND_FRAME_WRAP = 5;
    localparam PEND_FATAL = 4;
    localparam PEND_RESUME = 3;
    localparam PEND_FRAME_BEGIN = 2;
    localparam PEND_COMPLETION = 1;
    localparam PEND_OVERRUN = 0;

    // ==========================================================
    // Address decode
    wire sel_set;
    wire sel_clear;
    wire wr_set;
    wire wr_clear;

    assign sel_set = (reg_addr == SET_OFS);
    assign sel_clear = (reg_addr == CLEAR_OFS);
    assign wr_set = reg_wr & sel_set;
    assign wr_clear = reg_wr & sel_clear;

    // ==========================================================
    // Write data qualification
    wire [WORD_W-1:0] set_bits;
    wire [WORD_W-1:0] clear_bits;

    // Reserved bits can never be set
    assign set_bits = wr_set ? (reg_wdata & IMPL_MASK) : ZERO_WORD;
    // Same position in both views
    assign clear_bits = wr_clear ? reg_wdata : ZERO_WORD;

    // ==========================================================
    // Enable register, one slice per bit
    reg [WORD_W-1:0] enable_reg;
    wire [WORD_W-1:0] enable_next;

    genvar i;
    generate
        for (i = 0; i < WORD_W; i = i + 1) begin : g_bit
            wire impl_bit;
            wire set_req;
            wire clear_req;
            reg next_bit;

            assign impl_bit = IMPL_MASK[i];
            assign set_req = set_bits[i] & impl_bit;
            assign clear_req = clear_bits[i];

            // Clear wins if set and clear ever meet
            always @* begin
                next_bit = enable_reg[i];
                if (clear_req) begin
                    next_bit = 1'b0;
                end else if (set_req) begin
                    next_bit = 1'b1;
                end else begin
                    next_bit = enable_reg[i] & impl_bit;
                end
            end

            assign enable_next[i] = next_bit;
        end
    endgenerate

    always @(posedge ref_clk) begin
        if (rst || soft_rst) begin
            enable_reg <= RESET_VAL;
        end else begin
            enable_reg <= enable_next;
        end
    end

    assign irq_enable_view = enable_reg;

    // ==========================================================
    // Named enable fields
    wire master_irq_gate;
    wire ownership_change_en;
    wire root_port_change_en;
    wire frame_count_wrap_en;
    wire fatal_fault_en;
    wire resume_detect_en;
    wire frame_begin_en;
    wire completion_list_posted_en;
    wire sched_overrun_en;

    assign master_irq_gate = enable_reg[`MASTER_IRQ_GATE_BIT];
    assign ownership_change_en = enable_reg[`OWNERSHIP_CHANGE_BIT];
    assign root_port_change_en = enable_reg[`ROOT_PORT_CHANGE_BIT];
    assign frame_count_wrap_en = enable_reg[`FRAME_COUNT_WRAP_BIT];
    assign fatal_fault_en = enable_reg[`FATAL_FAULT_BIT];
    assign resume_detect_en = enable_reg[`RESUME_DETECT_BIT];
    assign frame_begin_en = enable_reg[`FRAME_BEGIN_BIT];
    assign completion_list_posted_en = enable_reg[`COMPLETION_POSTED_BIT];
    assign sched_overrun_en = enable_reg[`SCHED_OVERRUN_BIT];

    // ==========================================================
    // Event inputs
    // Flag bit 31 carries no event
    wire ownership_change_event;
    wire root_port_change_event;
    wire frame_count_wrap_event;
    wire fatal_fault_event;
    wire resume_detect_event;
    wire frame_begin_event;
    wire completion_list_posted_event;
    wire sched_overrun_event;

    assign ownership_change_event = irq_event_flags[`OWNERSHIP_CHANGE_BIT];
    assign root_port_change_event = irq_event_flags[`ROOT_PORT_CHANGE_BIT];
    assign frame_count_wrap_event = irq_event_flags[`FRAME_COUNT_WRAP_BIT];
    assign fatal_fault_event = irq_event_flags[`FATAL_FAULT_BIT];
    assign resume_detect_event = irq_event_flags[`RESUME_DETECT_BIT];
    assign frame_begin_event = irq_event_flags[`FRAME_BEGIN_BIT];
    assign completion_list_posted_event = irq_event_flags[`COMPLETION_POSTED_BIT];
    assign sched_overrun_event = irq_event_flags[`SCHED_OVERRUN_BIT];

    // ==========================================================
    // Interrupt output
    wire [EVENT_N-1:0] pending_vec;
    wire any_pending;
    reg irq_level;

    assign pending_vec[PEND_OWNERSHIP] = ownership_change_event & ownership_change_en;
    assign pending_vec[PEND_ROOT_PORT] = root_port_change_event & root_port_change_en;
    assign pending_vec[PEND_FRAME_WRAP] = frame_count_wrap_event & frame_count_wrap_en;
    assign pending_vec[PEND_FATAL] = fatal_fault_event & fatal_fault_en;
    assign pending_vec[PEND_RESUME] = resume_detect_event & resume_detect_en;
    assign pending_vec[PEND_FRAME_BEGIN] = frame_begin_event & frame_begin_en;
    assign pending_vec[PEND_COMPLETION] = completion_list_posted_event & completion_list_posted_en;
    assign pending_vec[PEND_OVERRUN] = sched_overrun_event & sched_overrun_en;
    assign any_pending = |pending_vec;

    // Gate masks every event source
    always @* begin
        irq_level = 1'b0;
        if (master_irq_gate) begin
            if (any_pending) begin
                irq_level = 1'b1;
            end
        end
    end

    assign irq_out = irq_level;

    // ==========================================================
    // Read path
    reg [WORD_W-1:0] rdata_next;

    // Both views return the live enable word
    // Unmapped offsets read zero; idle keeps last word
    always @* begin
        rdata_next = reg_rdata;
        if (reg_rd) begin
            case (reg_addr)
                SET_OFS: begin
                    rdata_next = enable_reg;
                end
                CLEAR_OFS: begin
                    rdata_next = enable_reg;
                end
                default: begin
                    rdata_next = ZERO_WORD;
                end
            endcase
        end
    end

    always @(posedge ref_clk) begin
        if (rst) begin
            reg_rdata <= ZERO_WORD;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

endmodule

// ---- ohci_irq_enable_pair_chk.sv ----
`timescale 1ns/1ps
module ohci_irq_enable_pair_chk(input wire ref_clk,rst,soft_rst,reg_wr,reg_rd,irq_out,
input wire [7:0] reg_addr,input wire [31:0] reg_wdata,reg_rdata,irq_event_flags,irq_enable_view);
default clocking @(posedge ref_clk); endclocking
default disable iff (rst);
wire [31:0] v=irq_enable_view;
wire ws=reg_wr&!soft_rst&reg_addr==8'h10;
wire wc=reg_wr&!soft_rst&reg_addr==8'h14;
chk_set_ones: assert property(ws|=>(v&$past(reg_wdata)&32'hC000007F)==
($past(reg_wdata)&32'hC000007F)) else $error("set lost");
chk_set_keep: assert property(ws|=>(v&$past(v))==$past(v)) else $error("set dropped");
chk_clr_ones: assert property(wc|=>!(v&$past(reg_wdata))) else $error("clear failed");
chk_clr_keep: assert property(wc|=>v==($past(v)&~$past(reg_wdata)))
else $error("clear bad");
chk_clr_read: assert property(reg_rd&&reg_addr==8'h14|=>reg_rdata==$past(v))
else $error("read");
chk_resv_zero: assert property(!(v&~32'hC000007F)) else $error("reserved set");
chk_soft_clear: assert property(soft_rst|=>v==0) else $error("soft reset");
chk_irq_gate: assert property(irq_out==(v[31]&&|(v[30:0]&irq_event_flags[30:0])))
else $error("irq wrong");
cover property(irq_out);
cover property(wc);
cover property(soft_rst);
endmodule
bind ohci_irq_enable_pair ohci_irq_enable_pair_chk chk_u(.*);

// ---- tb_ohci_irq_enable_pair.sv ----
`timescale 1ns/1ps
`include "ohci_irq_defines.vh"
`define CK(n,e,g) begin \
    n_checks++; \
    if ((g) !== (e)) begin \
        bad_count++; \
        $display("ERROR %s exp %h got %h", n, e, g); \
    end \
end
module tb_ohci_irq_enable_pair;
    reg ref_clk = 0;
    reg rst = 1;
    reg soft_rst = 0;
    reg reg_wr = 0;
    reg reg_rd = 0;
    reg [7:0] reg_addr = 0;
    reg [31:0] reg_wdata = 0;
    reg [31:0] irq_event_flags = 0;
    wire [31:0] reg_rdata;
    wire [31:0] irq_enable_view;
    wire irq_out;
    reg [31:0] seed = 32'h0000682A;
    reg [31:0] model = 0;
    reg [31:0] exp_rdata = 0;
    reg [31:0] wd;
    reg [7:0] wa;
    reg do_wr;
    reg do_rd;
    reg do_srst;
    reg rd_pending = 0;
    int bad_count = 0;
    int n_checks = 0;

    ohci_irq_enable_pair dut_u (
        .ref_clk(ref_clk),
        .rst(rst),
        .soft_rst(soft_rst),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .irq_event_flags(irq_event_flags),
        .irq_enable_view(irq_enable_view),
        .irq_out(irq_out)
    );

    // ==========================================================
    // Reference functions
    function [31:0] nx(input [31:0] v);
        reg [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        nx = t ^ (t << 5);
    endfunction

    function [31:0] exp_enable(input [31:0] old, input wr, input sr, input [7:0] ad,
        input [31:0] dat);
        if (sr) begin
            exp_enable = 32'h00000000;
        end else if (wr && ad == `IRQ_ENABLE_SET_OFS) begin
            exp_enable = old | (dat & `IRQ_ENABLE_MASK);
        end else if (wr && ad == `IRQ_ENABLE_CLEAR_OFS) begin
            exp_enable = old & ~dat;
        end else begin
            exp_enable = old;
        end
    endfunction

    function [31:0] exp_read(input [31:0] old, input [7:0] ad);
        if (ad == `IRQ_ENABLE_SET_OFS || ad == `IRQ_ENABLE_CLEAR_OFS) begin
            exp_read = old;
        end else begin
            exp_read = 32'h00000000;
        end
    endfunction

    function exp_irq(input [31:0] en, input [31:0] flags);
        exp_irq = en[`MASTER_IRQ_GATE_BIT] && (|(en[30:0] & flags[30:0]));
    endfunction

    task close_out;
        $display("bad %0d checks %0d", bad_count, n_checks);
        if (bad_count == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock and watchdog
    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    initial begin
        #20000;
        bad_count++;
        close_out;
    end

    // ==========================================================
    // Stimulus and checks
    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 300; i++) begin
            @(posedge ref_clk);
            seed = nx(seed);
            do_wr = (i < 3) | seed[0];
            do_rd = seed[1];
            do_srst = (i > 2) && (seed[7:4] == 4'h0);
            if (i == 0) begin
                wa = `IRQ_ENABLE_SET_OFS;
                wd = 32'hFFFFFFFF;
            end else if (i == 1) begin
                wa = `IRQ_ENABLE_CLEAR_OFS;
                wd = 32'h00000001;
            end else if (i == 2) begin
                wa = `IRQ_ENABLE_SET_OFS;
                wd = 32'h00000000;
            end else begin
                wa = seed[3] ? (seed[2] ? 8'h3C : `IRQ_ENABLE_CLEAR_OFS) : `IRQ_ENABLE_SET_OFS;
                wd = nx(~seed);
            end
            // Reserved bits always written as zero
            wd = wd & `IRQ_ENABLE_MASK;
            reg_wr <= do_wr;
            reg_rd <= do_rd;
            reg_addr <= wa;
            reg_wdata <= wd;
            soft_rst <= do_srst;
            irq_event_flags <= seed ^ wd;
            #1;
            `CK("view", model, irq_enable_view)
            `CK("irq", exp_irq(model, irq_event_flags), irq_out)
            if (rd_pending) begin
                `CK("rdata", exp_rdata, reg_rdata)
            end
            rd_pending = do_rd;
            if (do_rd) begin
                exp_rdata = exp_read(model, wa);
            end
            model = exp_enable(model, do_wr, do_srst, wa, wd);
        end
        close_out;
    end
endmodule
